// ### tsa_scratchpad.sv
// Scratchpad, alarm compare, identity code and nonvolatile transfers
//
// Operation
// RULE1 - Temperature resets to plus eighty-five code
// RULE2 - Temperature is sixteen-bit sign-extended sixteenths
// RULE3 - Low bits undefined at reduced resolution
// RULE4 - Compare against limits after every conversion
// RULE5 - Limits are signed eight-bit values
// RULE6 - Compare uses temperature bits eleven to four
// RULE7 - Alarm when at or beyond either limit
// RULE8 - Alarm flag recomputed on each conversion
// RULE9 - Alarm search answered only when flagged
// RULE10 - Master reconverts after limits change
// RULE11 - Identity: family, serial, CRC byte
// RULE12 - CRC polynomial x8 x5 x4 one
// RULE13 - Bytes zero, one show temperature, read-only
// RULE14 - Bytes two to four writable, rest fixed
// RULE15 - Byte eight is CRC of bytes 0-7
// RULE16 - CRC tracks scratchpad contents
// RULE17 - Write stores bytes two, three, four
// RULE18 - Read sends bytes ascending from zero
// RULE19 - Copy moves three bytes to nonvolatile
// RULE20 - Power-up reloads nonvolatile bytes
// RULE21 - Recall reloads; status zero then one
// RULE22 - Resolution bits default to twelve-bit
// RULE23 - Reserved configuration bits ignore writes
// RULE24 - Limit bytes usable as plain storage
// RULE25 - Copy and recall are atomic

`timescale 1ns/1ps
`default_nettype none
`include "tsa_cfg.svh"

module tsa_scratchpad
    import tsa_pkg::*;
#(
    parameter logic [7:0]  FAMILY_CODE   = `TSA_FAMILY_CODE,
    parameter logic [47:0] SERIAL_NUMBER = `TSA_SERIAL_NUMBER,
    parameter logic [3:0]  RECALL_CYCLES = `TSA_RECALL_CYCLES
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic        i_conv_done,
    input  wire logic [15:0] i_conv_temp,
    input  wire logic        i_wr_strobe,
    input  wire logic [1:0]  i_wr_index,
    input  wire logic [7:0]  i_wr_data,
    input  wire logic [3:0]  i_rd_addr,
    input  wire logic        i_copy_cmd,
    input  wire logic        i_nonvolatile_reload_cmd,
    input  wire logic        i_alarm_search_cmd,
    output logic [7:0]       o_rd_data,
    output logic             o_recall_status,
    output logic             o_busy,
    output logic             o_alarm_flag,
    output logic             o_search_join,
    output logic [1:0]       o_resolution,
    output logic [63:0]      o_identity
);

    // Serial CRC over a byte, LSB first, reflected form of x8+x5+x4+1
    function automatic logic [7:0] crc_byte(input logic [7:0] crc,
                                            input logic [7:0] data);
        logic [7:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ data[i]) begin
                c = (c >> 1) ^ `TSA_CRC_POLY; // [RULE12]
            end else begin
                c = c >> 1;
            end
        end
        return c;
    endfunction

    logic [15:0] temp_q,   temp_d;
    tsa_nv_t     pad_q,    pad_d;
    tsa_nv_t     nv_q,     nv_d;
    logic        alarm_q,  alarm_d;
    logic [3:0]  cnt_q,    cnt_d;
    logic [7:0]  rd_q,     rd_d;
    tsa_state_t  state_q,  state_d;
    logic [7:0]  crc_q,    crc_d;
    logic [15:0] masked;
    logic signed [7:0] temp_cmp;
    logic [7:0]  bytes [8];

    // Conversion result trimmed to the active resolution
    always_comb begin
        masked = i_conv_temp;
        case (tsa_res_t'(pad_q.config_byte[6:5])) // [RULE22]
            TSA_RES_11: masked[0]   = 1'b0;        // [RULE3]
            TSA_RES_10: masked[1:0] = 2'b00;       // [RULE3]
            TSA_RES_9:  masked[2:0] = 3'b000;      // [RULE3]
            default:    masked      = i_conv_temp;
        endcase
    end

    assign temp_cmp = signed'(temp_d[11:4]); // [RULE6]

    always_comb begin
        temp_d  = temp_q;
        alarm_d = alarm_q;
        if (i_conv_done) begin
            temp_d = masked; // [RULE2]
            // Signed compare, both limits inclusive
            alarm_d = (temp_cmp <= signed'(pad_q.alarm_low)) ||
                      (temp_cmp >= signed'(pad_q.alarm_high)); // [RULE4] [RULE5] [RULE7] [RULE8]
        end
    end

    // Scratchpad writes and the nonvolatile transfer sequencer
    always_comb begin
        pad_d   = pad_q;
        nv_d    = nv_q;
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            TSA_IDLE: begin
                if (i_nonvolatile_reload_cmd) begin
                    state_d = TSA_RECALL;
                    cnt_d   = RECALL_CYCLES;
                end else if (i_copy_cmd) begin
                    state_d = TSA_COPY;
                end else if (i_wr_strobe) begin
                    if (i_wr_index == 2'h0) begin
                        pad_d.alarm_high = i_wr_data; // [RULE17] [RULE24]
                    end else if (i_wr_index == 2'h1) begin
                        pad_d.alarm_low = i_wr_data;  // [RULE17] [RULE24]
                    end else if (i_wr_index == 2'h2) begin
                        pad_d.config_byte = (i_wr_data & `TSA_CFG_WR_MASK)
                                          | `TSA_CFG_FIXED; // [RULE23] [RULE17]
                    end
                end
            end
            TSA_RECALL: begin
                if (cnt_q == 4'h1) begin
                    pad_d   = nv_q; // [RULE21] [RULE25]
                    state_d = TSA_IDLE;
                end
                cnt_d = cnt_q - 4'h1;
            end
            TSA_COPY: begin
                nv_d    = pad_q; // [RULE19] [RULE25]
                state_d = TSA_IDLE;
            end
            default: state_d = TSA_IDLE;
        endcase
    end

    // Fixed scratchpad image for read and CRC
    always_comb begin
        bytes[0] = temp_q[7:0];  // [RULE13]
        bytes[1] = temp_q[15:8]; // [RULE13]
        bytes[2] = pad_q.alarm_high; // [RULE14]
        bytes[3] = pad_q.alarm_low;
        bytes[4] = pad_q.config_byte;
        bytes[5] = `TSA_RSVD_A_VAL;
        bytes[6] = `TSA_RSVD_B_VAL;
        bytes[7] = `TSA_RSVD_C_VAL;
        crc_d = 8'h00;
        for (int i = 0; i < 8; i++) begin
            crc_d = crc_byte(crc_d, bytes[i]); // [RULE15] [RULE16]
        end
    end

    // Registered read port; one cycle latency, CRC lags data by one cycle
    always_comb begin
        if (i_rd_addr == `TSA_OFS_CRC) begin
            rd_d = crc_q; // [RULE15]
        end else if (i_rd_addr < `TSA_OFS_CRC) begin
            rd_d = bytes[i_rd_addr[2:0]]; // [RULE18]
        end else begin
            rd_d = 8'h00;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            temp_q  <= `TSA_TEMP_RESET; // [RULE1]
            // Fixed configuration bits stay visible even before the reload
            pad_q   <= '{8'h00, 8'h00, `TSA_CFG_RESET};
            nv_q    <= '{8'h00, 8'h00, `TSA_CFG_RESET};
            alarm_q <= 1'b0;
            cnt_q   <= RECALL_CYCLES;
            state_q <= TSA_RECALL; // Power-up reload [RULE20]
            rd_q    <= 8'h00;
            crc_q   <= 8'h00;
        end else begin
            temp_q  <= temp_d;
            pad_q   <= pad_d;
            nv_q    <= nv_d;
            alarm_q <= alarm_d;
            cnt_q   <= cnt_d;
            state_q <= state_d;
            rd_q    <= rd_d;
            crc_q   <= crc_d;
        end
    end

    assign o_rd_data       = rd_q;
    assign o_recall_status = (state_q != TSA_RECALL); // [RULE21]
    assign o_busy          = (state_q != TSA_IDLE);
    assign o_alarm_flag    = alarm_q;
    assign o_search_join   = i_alarm_search_cmd & alarm_q; // [RULE9]
    assign o_resolution    = pad_q.config_byte[6:5];

    // Identity CRC folds the family byte, then six serial bytes, LSB first
    logic [55:0] id_body;
    logic [7:0]  id_crc [8];

    assign id_body   = {SERIAL_NUMBER, FAMILY_CODE};
    assign id_crc[0] = 8'h00;

    for (genvar g = 0; g < 7; g++) begin : g_id_crc
        assign id_crc[g + 1] = crc_byte(id_crc[g], id_body[g*8 +: 8]); // [RULE12]
    end

    // Family code lowest, CRC over lower 56 bits on top; codes are arbitrary
    assign o_identity = {id_crc[7], id_body}; // [RULE11]

endmodule

`default_nettype wire

// ### tsa_cfg.svh
// Constants for the thermometer scratchpad and alarm block
`ifndef TSA_CFG_SVH
`define TSA_CFG_SVH
`define TSA_TEMP_RESET      16'h0550
`define TSA_OFS_TEMP_LO     4'h0
`define TSA_OFS_TEMP_HI     4'h1
`define TSA_OFS_ALARM_HI    4'h2
`define TSA_OFS_ALARM_LO    4'h3
`define TSA_OFS_CONFIG      4'h4
`define TSA_OFS_RSVD_A      4'h5
`define TSA_OFS_RSVD_B      4'h6
`define TSA_OFS_RSVD_C      4'h7
`define TSA_OFS_CRC         4'h8
`define TSA_CFG_WR_MASK     8'h60
`define TSA_CFG_FIXED       8'h1F
`define TSA_CFG_RESET       8'h7F
`define TSA_RSVD_A_VAL      8'hFF
`define TSA_RSVD_B_VAL      8'h00
`define TSA_RSVD_C_VAL      8'h10
`define TSA_CRC_POLY        8'h8C
`define TSA_FAMILY_CODE     8'h5A
`define TSA_SERIAL_NUMBER   48'h0000_0000_0001
`define TSA_RECALL_CYCLES   4'h8
`endif

// ### tsa_pkg.sv
// Types for the thermometer scratchpad and alarm block
package tsa_pkg;
    typedef enum logic [1:0] {
        TSA_RES_9  = 2'h0,
        TSA_RES_10 = 2'h1,
        TSA_RES_11 = 2'h2,
        TSA_RES_12 = 2'h3
    } tsa_res_t;

    typedef struct packed {
        logic [7:0] alarm_high;
        logic [7:0] alarm_low;
        logic [7:0] config_byte;
    } tsa_nv_t;

    typedef enum {
        TSA_IDLE,
        TSA_RECALL,
        TSA_COPY
    } tsa_state_t;
endpackage

// ### tsa_scratchpad_checker.sv
// Port-level assertions for the scratchpad block
`timescale 1ns/1ps
`default_nettype none
module tsa_scratchpad_checker (
    input wire logic       i_ref_clk,
    input wire logic       i_reset,
    input wire logic       i_conv_done,
    input wire logic       i_wr_strobe,
    input wire logic [3:0] i_rd_addr,
    input wire logic       i_copy_cmd,
    input wire logic       i_nonvolatile_reload_cmd,
    input wire logic       i_alarm_search_cmd,
    input wire logic [7:0] o_rd_data,
    input wire logic       o_recall_status,
    input wire logic       o_busy,
    input wire logic       o_alarm_flag,
    input wire logic       o_search_join,
    input wire logic [1:0] o_resolution
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    sequence s_reload;
        !o_recall_status ##[1:9] o_recall_status;
    endsequence
    property p_join;
        o_search_join == (i_alarm_search_cmd && o_alarm_flag);
    endproperty
    a_join: assert property (p_join) else $error("search join wrong");
    property p_recall;
        i_nonvolatile_reload_cmd && !o_busy |=> s_reload;
    endproperty
    a_recall: assert property (p_recall) else $error("recall status");
    property p_copy;
        i_copy_cmd && !i_nonvolatile_reload_cmd && !o_busy |=> ##[0:2] !o_busy;
    endproperty
    a_copy: assert property (p_copy) else $error("copy hangs");
    property p_idle;
        !o_busy |-> o_recall_status;
    endproperty
    a_idle: assert property (p_idle) else $error("status low at idle");
    property p_rsvd;
        i_rd_addr == 4'h5 |=> o_rd_data == 8'hFF;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved byte");
    property p_cfg;
        i_rd_addr == 4'h4 |=> (o_rd_data & 8'h9F) == 8'h1F;
    endproperty
    a_cfg: assert property (p_cfg) else $error("config fixed bits");
    property p_res;
        i_rd_addr == 4'h4 && !o_busy && !i_wr_strobe
            |=> o_rd_data[6:5] == $past(o_resolution);
    endproperty
    a_res: assert property (p_res) else $error("resolution bits");
    property p_alarm;
        !i_conv_done |=> $stable(o_alarm_flag);
    endproperty
    a_alarm: assert property (p_alarm) else $error("flag moved");
endmodule
bind tsa_scratchpad tsa_scratchpad_checker i_chk (.*);
`default_nettype wire

// ### tsa_master_model.sv
// Bus master model that reports finished conversions
`timescale 1ns/1ps
`default_nettype none
module tsa_master_model (
    input  wire logic   i_clk,
    output logic        o_conv_done,
    output logic [15:0] o_conv_temp
);
    initial begin
        o_conv_done = 1'b0;
        o_conv_temp = 16'h0000;
    end
    // Reconverting after a limit change keeps the flag honest
    task convert(input logic [15:0] t);
        @(posedge i_clk);
        o_conv_done <= 1'b1;
        o_conv_temp <= t;
        @(posedge i_clk);
        o_conv_done <= 1'b0;
        o_conv_temp <= ~t;
    endtask
endmodule
`default_nettype wire

// ### tsa_scratchpad_tb_top.sv
// Self-checking bench for the scratchpad block
`timescale 1ns/1ps
`default_nettype none
`include "tsa_cfg.svh"
module tsa_scratchpad_tb_top;
    import tsa_pkg::*;
    logic        i_ref_clk = 1'b0, i_reset = 1'b1, i_wr_strobe = 1'b0;
    logic        i_copy_cmd = 1'b0, i_nonvolatile_reload_cmd = 1'b0;
    logic        i_alarm_search_cmd = 1'b0, i_conv_done;
    logic [1:0]  i_wr_index = 2'h0, o_resolution;
    logic [7:0]  i_wr_data = 8'h00, o_rd_data;
    logic [3:0]  i_rd_addr = 4'h0;
    logic [15:0] i_conv_temp, tv [4] = '{16'h00A2, 16'hFF6F, 16'hFF7F, 16'h0191};
    logic [63:0] o_identity, id_exp;
    logic        o_recall_status, o_busy, o_alarm_flag, o_search_join;
    logic        ea [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    int          error_cnt = 0, tests_run = 0;
    tsa_master_model i_mst (.i_clk(i_ref_clk), .o_conv_done(i_conv_done),
        .o_conv_temp(i_conv_temp));
    // Family code 8'hA3 is arbitrary
    tsa_scratchpad #(.FAMILY_CODE(8'hA3)) i_dut (.*);
    initial forever #2 i_ref_clk = ~i_ref_clk;
    function automatic logic [7:0] crc(logic [63:0] v, int nb);
        logic [7:0] c;
        c = 8'h00;
        for (int k = 0; k < nb * 8; k++)
            c = (c >> 1) ^ ((c[0] ^ v[k]) ? 8'h8C : 8'h00);
        return c;
    endfunction
    task chk(string n, logic [15:0] s, logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task wrb(logic [1:0] i, logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr_strobe <= 1'b1;
        i_wr_index <= i;
        i_wr_data <= d;
        @(posedge i_ref_clk);
        i_wr_strobe <= 1'b0;
    endtask
    task rdb(logic [3:0] a, logic [7:0] e);
        @(posedge i_ref_clk);
        i_rd_addr <= a;
        @(posedge i_ref_clk);
        #1 chk("rd_data", {8'h00, o_rd_data}, {8'h00, e});
    endtask
    task cmd(bit r);
        @(posedge i_ref_clk);
        if (r) i_nonvolatile_reload_cmd <= 1'b1; else i_copy_cmd <= 1'b1;
        @(posedge i_ref_clk);
        i_nonvolatile_reload_cmd <= 1'b0;
        i_copy_cmd <= 1'b0;
    endtask
    // Bounded so a stuck busy ends as a mismatch, not a hang
    task idle;
        int n;
        n = 0;
        #1;
        while (o_busy !== 1'b0 && n < 40) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        chk("busy", {15'h0000, o_busy}, 16'h0000);
    endtask
    task summarize;
        $display("Checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        error_cnt++;
        summarize;
    end
    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        idle;
        rdb(4'h0, 8'h50);
        rdb(4'h1, 8'h05);
        rdb(4'h4, 8'h7F);
        rdb(4'h6, 8'h00);
        rdb(4'h5, 8'hFF);
        rdb(4'h8, crc(64'h1000_FF7F_0000_0550, 8));
        id_exp = {crc({8'h00, `TSA_SERIAL_NUMBER, 8'hA3}, 7),
            `TSA_SERIAL_NUMBER, 8'hA3};
        for (int q = 0; q < 4; q++)
            chk("id", o_identity[q*16 +: 16], id_exp[q*16 +: 16]);
        wrb(2'h0, 8'h19);
        wrb(2'h1, 8'hF6);
        wrb(2'h2, 8'h00);
        wrb(2'h3, 8'hAA);
        rdb(4'h2, 8'h19);
        rdb(4'h3, 8'hF6);
        rdb(4'h4, 8'h1F);
        chk("res", {14'h0000, o_resolution}, {14'h0000, TSA_RES_9});
        rdb(4'h7, 8'h10);
        rdb(4'h8, crc(64'h1000_FF1F_F619_0550, 8));
        i_mst.convert(16'h0191);
        rdb(4'h0, 8'h90);
        wrb(2'h2, 8'h7F);
        i_alarm_search_cmd <= 1'b1;
        foreach (tv[k]) begin
            i_mst.convert(tv[k]);
            #1 chk("alarm", {15'h0000, o_alarm_flag}, {15'h0000, ea[k]});
            chk("join", {15'h0000, o_search_join}, {15'h0000, ea[k]});
            rdb(4'h1, tv[k][15:8]);
        end
        @(posedge i_ref_clk);
        i_alarm_search_cmd <= 1'b0;
        #1 chk("join", {15'h0000, o_search_join}, 16'h0000);
        wrb(2'h0, 8'h33);
        cmd(1'b0);
        idle;
        wrb(2'h0, 8'h44);
        cmd(1'b1);
        #1 chk("recall", {15'h0000, o_recall_status}, 16'h0000);
        idle;
        rdb(4'h2, 8'h33);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        idle;
        rdb(4'h2, 8'h00);
        rdb(4'h4, 8'h7F);
        rdb(4'h0, 8'h50);
        summarize;
    end
endmodule
`default_nettype wire
